/* File: hw/ea_pkg.sv */
// shared constants and types of the operand addressing unit
package ea_pkg;
  // addressing modes (seventeen, in seven groups)
  typedef enum logic [4:0] {
    MODE_INHERENT = 5'h00,
    MODE_IMMEDIATE = 5'h01,
    MODE_DIR_SHORT = 5'h02,
    MODE_DIR_LONG = 5'h03,
    MODE_IDX_NOOFS = 5'h04,
    MODE_IDX_SHORT = 5'h05,
    MODE_IDX_LONG = 5'h06,
    MODE_IND_SHORT = 5'h07,
    MODE_IND_LONG = 5'h08,
    MODE_INDIDX_SHORT = 5'h09,
    MODE_INDIDX_LONG = 5'h0a,
    MODE_REL_DIR = 5'h0b,
    MODE_REL_IND = 5'h0c,
    MODE_BIT_DIR = 5'h0d,
    MODE_BIT_IND = 5'h0e,
    MODE_BITREL_DIR = 5'h0f,
    MODE_BITREL_IND = 5'h10
  } mode_e;
  localparam int MODE_COUNT = 17;
  localparam int GROUP_COUNT = 7;
  // mode groups
  typedef enum logic [2:0] {
    GRP_INHERENT = 3'h0,
    GRP_IMMEDIATE = 3'h1,
    GRP_DIRECT = 3'h2,
    GRP_INDEXED = 3'h3,
    GRP_INDIRECT = 3'h4,
    GRP_RELATIVE = 3'h5,
    GRP_BIT = 3'h6
  } group_e;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] PAGE_ZERO_HI = 16'h0000;
  localparam logic [1:0] OPBYTES_NONE = 2'h0;
  localparam logic [1:0] OPBYTES_ONE = 2'h1;
  localparam logic [1:0] OPBYTES_TWO = 2'h2;
  localparam logic [1:0] OPBYTES_THREE = 2'h3;
  localparam logic [15:0] ADDR_INC = 16'h0001;
  // sequencer states, gray in listing order
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH1 = 3'b001,
    ST_FETCH2 = 3'b011,
    ST_PTR_HI = 3'b010,
    ST_PTR_LO = 3'b110,
    ST_DONE = 3'b111,
    ST_FETCH3 = 3'b101
  } state_e;
endpackage

/* File: hw/ea_mode_decode.sv */
// decoder of operand byte count and mode properties
`timescale 1ns/1ns
module ea_mode_decode (
  input wire logic [4:0] mode,
  output logic [1:0] opBytes,
  output logic [2:0] modeGroup,
  output logic isIndirect,
  output logic isIndexed,
  output logic isLongPtr,
  output logic isShort
);
  // byte count per mode, one entry for each of the seventeen modes
  always_comb begin
    opBytes = ea_pkg::OPBYTES_NONE;
    modeGroup = ea_pkg::GRP_INHERENT;
    isIndirect = 1'b0;
    isIndexed = 1'b0;
    isLongPtr = 1'b0;
    isShort = 1'b1;
    case (ea_pkg::mode_e'(mode))
      ea_pkg::MODE_INHERENT: begin
        opBytes = ea_pkg::OPBYTES_NONE;
      end
      ea_pkg::MODE_IMMEDIATE: begin
        opBytes = ea_pkg::OPBYTES_ONE;
        modeGroup = ea_pkg::GRP_IMMEDIATE;
      end
      ea_pkg::MODE_DIR_SHORT: begin
        opBytes = ea_pkg::OPBYTES_ONE;
        modeGroup = ea_pkg::GRP_DIRECT;
      end
      ea_pkg::MODE_DIR_LONG: begin
        opBytes = ea_pkg::OPBYTES_TWO;
        modeGroup = ea_pkg::GRP_DIRECT;
        isShort = 1'b0;
      end
      ea_pkg::MODE_IDX_NOOFS: begin
        modeGroup = ea_pkg::GRP_INDEXED;
        isIndexed = 1'b1;
      end
      ea_pkg::MODE_IDX_SHORT: begin
        opBytes = ea_pkg::OPBYTES_ONE;
        modeGroup = ea_pkg::GRP_INDEXED;
        isIndexed = 1'b1;
      end
      ea_pkg::MODE_IDX_LONG: begin
        opBytes = ea_pkg::OPBYTES_TWO;
        modeGroup = ea_pkg::GRP_INDEXED;
        isIndexed = 1'b1;
        isShort = 1'b0;
      end
      ea_pkg::MODE_IND_SHORT: begin
        opBytes = ea_pkg::OPBYTES_ONE;
        modeGroup = ea_pkg::GRP_INDIRECT;
        isIndirect = 1'b1;
      end
      ea_pkg::MODE_IND_LONG: begin
        opBytes = ea_pkg::OPBYTES_ONE;
        modeGroup = ea_pkg::GRP_INDIRECT;
        isIndirect = 1'b1;
        isLongPtr = 1'b1;
        isShort = 1'b0;
      end
      ea_pkg::MODE_INDIDX_SHORT: begin
        opBytes = ea_pkg::OPBYTES_ONE;
        modeGroup = ea_pkg::GRP_INDIRECT;
        isIndirect = 1'b1;
        isIndexed = 1'b1;
      end
      ea_pkg::MODE_INDIDX_LONG: begin
        opBytes = ea_pkg::OPBYTES_ONE;
        modeGroup = ea_pkg::GRP_INDIRECT;
        isIndirect = 1'b1;
        isIndexed = 1'b1;
        isLongPtr = 1'b1;
        isShort = 1'b0;
      end
      ea_pkg::MODE_REL_DIR: begin
        opBytes = ea_pkg::OPBYTES_ONE;
        modeGroup = ea_pkg::GRP_RELATIVE;
      end
      ea_pkg::MODE_REL_IND: begin
        opBytes = ea_pkg::OPBYTES_ONE;
        modeGroup = ea_pkg::GRP_RELATIVE;
        isIndirect = 1'b1;
      end
      ea_pkg::MODE_BIT_DIR: begin
        opBytes = ea_pkg::OPBYTES_ONE;
        modeGroup = ea_pkg::GRP_BIT;
      end
      ea_pkg::MODE_BIT_IND: begin
        opBytes = ea_pkg::OPBYTES_ONE;
        modeGroup = ea_pkg::GRP_BIT;
        isIndirect = 1'b1;
      end
      ea_pkg::MODE_BITREL_DIR: begin
        opBytes = ea_pkg::OPBYTES_TWO;
        modeGroup = ea_pkg::GRP_BIT;
      end
      ea_pkg::MODE_BITREL_IND: begin
        opBytes = ea_pkg::OPBYTES_TWO;
        modeGroup = ea_pkg::GRP_BIT;
        isIndirect = 1'b1;
      end
      default: begin
        // unknown code: treated as inherent, no bytes fetched
        opBytes = ea_pkg::OPBYTES_NONE;
      end
    endcase
  end
endmodule

/* File: hw/ea_adder.sv */
// unsigned 16-bit effective address adder
`timescale 1ns/1ns
module ea_adder (
  input wire logic [15:0] base,
  input wire logic [7:0] index,
  input wire logic useIndex,
  output logic [15:0] sum
);
  // zero-extended index, no sign; wraps at the top of the space
  always_comb begin
    sum = base + (useIndex ? {8'h00, index} : 16'h0000);
  end
endmodule

/* File: hw/cpu_addressing_mode_ea_gen.sv */
// operand byte fetch and effective address sequencer of the cpu core
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ns
module cpu_addressing_mode_ea_gen (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [4:0] mode,
  input wire logic useSecondIndex,
  input wire logic rmwOp,
  input wire logic [15:0] operandPc,
  input wire logic [7:0] indexFirst,
  input wire logic [7:0] indexSecond,
  input wire logic [7:0] memRdData,
  output logic memRd_ff,
  output logic [15:0] memAddr_ff,
  output logic busy_ff,
  output logic done_ff,
  output logic modeError_ff,
  output logic [15:0] effAddr_ff,
  output logic [7:0] immValue_ff,
  output logic immValid_ff,
  output logic [15:0] nextPc_ff,
  output logic [2:0] modeGroup_ff,
  output logic [1:0] opBytes_ff
);
  // ----------------------------------------------------------------
  // decode of the requested mode
  // ----------------------------------------------------------------
  logic [1:0] decBytes; // operand bytes after opcode
  logic [2:0] decGroup; // mode group
  logic decIndirect; // pointer read needed, except bit-relative indirect
  logic decIndexed; // index register added
  logic decLongPtr; // pointer is a word
  logic decShort; // short variant

  ea_mode_decode uDecode (
    .mode(mode),
    .opBytes(decBytes),
    .modeGroup(decGroup),
    .isIndirect(decIndirect),
    .isIndexed(decIndexed),
    .isLongPtr(decLongPtr),
    .isShort(decShort)
  );

  // ----------------------------------------------------------------
  // latched instruction context
  // ----------------------------------------------------------------
  ea_pkg::state_e state_ff; // sequencer state
  logic [4:0] mode_ff; // mode held for the whole sequence
  logic [1:0] bytesLeft_ff; // operand bytes to fetch, two for bit-relative indirect, fixed at start
  logic indirect_ff;
  logic indexed_ff;
  logic longPtr_ff;
  logic [7:0] index_ff; // index chosen at start
  logic [15:0] fetchPc_ff; // address of next operand byte
  logic [15:0] collect_ff; // operand bytes gathered, big end first
  logic [15:0] eaBase; // base before index add
  logic [15:0] eaSum; // base plus index

  // a request is legal only if its mode is known and rmw is short
  function automatic logic modeLegal(input logic [4:0] m, input logic isShortM,
                                     input logic rmw);
    logic known;
    known = (m <= ea_pkg::MODE_BITREL_IND);
    modeLegal = known && (!rmw || isShortM);
  endfunction

  // page-zero address from one byte
  function automatic logic [15:0] pageZero(input logic [7:0] b);
    pageZero = ea_pkg::PAGE_ZERO_HI | {8'h00, b};
  endfunction

  logic accept; // start taken this cycle
  assign accept = start && !busy_ff;

  // ----------------------------------------------------------------
  // address adder; index is zero-extended, sum is 16 bits
  // ----------------------------------------------------------------
  ea_adder uAdder (
    .base(eaBase),
    .index(index_ff),
    .useIndex(indexed_ff),
    .sum(eaSum)
  );

  // base comes from collected bytes: short forms fill only the low byte
  always_comb begin
    eaBase = collect_ff;
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // fetch: operand bytes in order; then pointer bytes when indirect with a single operand byte
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff <= ea_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        ea_pkg::ST_IDLE: begin
          if (accept && modeLegal(mode, decShort, rmwOp)) begin
            // inherent and no-offset indexed go straight to done
            if (decBytes == ea_pkg::OPBYTES_NONE) begin
              state_ff <= ea_pkg::ST_DONE;
            end else begin
              state_ff <= ea_pkg::ST_FETCH1;
            end
          end
        end
        ea_pkg::ST_FETCH1: begin
          if (bytesLeft_ff > ea_pkg::OPBYTES_ONE) begin
            state_ff <= ea_pkg::ST_FETCH2;
          end else if (indirect_ff) begin
            state_ff <= longPtr_ff ? ea_pkg::ST_PTR_HI : ea_pkg::ST_PTR_LO;
          end else begin
            state_ff <= ea_pkg::ST_DONE;
          end
        end
        ea_pkg::ST_FETCH2: begin
          // third byte of bit-relative indirect is a branch offset; bytesLeft_ff never exceeds two, so it is not fetched
          if (bytesLeft_ff > ea_pkg::OPBYTES_TWO) begin
            state_ff <= ea_pkg::ST_FETCH3;
          end else begin
            state_ff <= ea_pkg::ST_DONE;
          end
        end
        ea_pkg::ST_FETCH3: begin
          state_ff <= ea_pkg::ST_DONE;
        end
        ea_pkg::ST_PTR_HI: begin
          state_ff <= ea_pkg::ST_PTR_LO;
        end
        ea_pkg::ST_PTR_LO: begin
          state_ff <= ea_pkg::ST_DONE;
        end
        ea_pkg::ST_DONE: begin
          state_ff <= ea_pkg::ST_IDLE;
        end
        default: begin
          state_ff <= ea_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // context captured when a request is taken
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_ff <= 5'h00;
      bytesLeft_ff <= ea_pkg::OPBYTES_NONE;
      indirect_ff <= 1'b0;
      indexed_ff <= 1'b0;
      longPtr_ff <= 1'b0;
      index_ff <= 8'h00;
    end else if (state_ff == ea_pkg::ST_IDLE && accept) begin
      mode_ff <= mode;
      // bit-relative indirect fetches two bytes, as many as the bit-relative direct
      bytesLeft_ff <= (ea_pkg::mode_e'(mode) == ea_pkg::MODE_BITREL_IND) ?
                      ea_pkg::OPBYTES_TWO : decBytes;
      indirect_ff <= decIndirect;
      indexed_ff <= decIndexed;
      longPtr_ff <= decLongPtr;
      index_ff <= useSecondIndex ? indexSecond : indexFirst;
    end
  end

  // operand and pointer byte collection; read data stand while the strobe is high
  always_ff @(posedge core_clk) begin
    if (reset) begin
      collect_ff <= 16'h0000;
    end else begin
      case (state_ff)
        ea_pkg::ST_IDLE: begin
          if (accept) begin
            collect_ff <= 16'h0000;
          end
        end
        ea_pkg::ST_FETCH1: begin
          // first byte lands low; a second byte shifts it high
          collect_ff <= pageZero(memRdData);
        end
        ea_pkg::ST_FETCH2: begin
          collect_ff <= {collect_ff[7:0], memRdData};
        end
        ea_pkg::ST_PTR_HI: begin
          collect_ff <= {memRdData, 8'h00};
        end
        ea_pkg::ST_PTR_LO: begin
          // byte pointer replaces all; word pointer completes low half
          collect_ff <= longPtr_ff ? {collect_ff[15:8], memRdData} :
                        pageZero(memRdData);
        end
        default: begin
          collect_ff <= collect_ff;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // memory bus: a read is issued the cycle before its data are used
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      memRd_ff <= 1'b0;
      memAddr_ff <= 16'h0000;
      fetchPc_ff <= 16'h0000;
    end else begin
      memRd_ff <= 1'b0;
      case (state_ff)
        ea_pkg::ST_IDLE: begin
          if (accept && modeLegal(mode, decShort, rmwOp) &&
              decBytes != ea_pkg::OPBYTES_NONE) begin
            memRd_ff <= 1'b1;
            memAddr_ff <= operandPc;
            fetchPc_ff <= operandPc + ea_pkg::ADDR_INC;
          end
        end
        ea_pkg::ST_FETCH1: begin
          if (bytesLeft_ff > ea_pkg::OPBYTES_ONE) begin
            memRd_ff <= 1'b1;
            memAddr_ff <= fetchPc_ff;
            fetchPc_ff <= fetchPc_ff + ea_pkg::ADDR_INC;
          end else if (indirect_ff) begin
            // pointer lives in page zero at the fetched byte
            memRd_ff <= 1'b1;
            memAddr_ff <= pageZero(memRdData);
          end
        end
        ea_pkg::ST_FETCH2: begin
          if (bytesLeft_ff > ea_pkg::OPBYTES_TWO) begin
            memRd_ff <= 1'b1;
            memAddr_ff <= fetchPc_ff;
            fetchPc_ff <= fetchPc_ff + ea_pkg::ADDR_INC;
          end
        end
        ea_pkg::ST_PTR_HI: begin
          memRd_ff <= 1'b1;
          memAddr_ff <= memAddr_ff + ea_pkg::ADDR_INC;
        end
        default: begin
          memAddr_ff <= memAddr_ff;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // results
  // ----------------------------------------------------------------
  // status and result outputs; done pulses one cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      modeError_ff <= 1'b0;
      effAddr_ff <= 16'h0000;
      immValue_ff <= 8'h00;
      immValid_ff <= 1'b0;
      nextPc_ff <= 16'h0000;
      modeGroup_ff <= ea_pkg::GRP_INHERENT;
      opBytes_ff <= ea_pkg::OPBYTES_NONE;
    end else begin
      done_ff <= 1'b0;
      modeError_ff <= 1'b0;
      if (state_ff == ea_pkg::ST_IDLE && accept) begin
        if (modeLegal(mode, decShort, rmwOp)) begin
          busy_ff <= 1'b1;
          modeGroup_ff <= decGroup;
          opBytes_ff <= (ea_pkg::mode_e'(mode) == ea_pkg::MODE_BITREL_IND) ?
                        ea_pkg::OPBYTES_THREE : decBytes;
          nextPc_ff <= operandPc +
            {14'h0000, (ea_pkg::mode_e'(mode) == ea_pkg::MODE_BITREL_IND) ?
             ea_pkg::OPBYTES_THREE : decBytes};
        end else begin
          // long mode on read-modify-write, or unknown mode
          modeError_ff <= 1'b1;
        end
      end
      if (state_ff == ea_pkg::ST_DONE) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
        // immediate: the byte is the operand, not an address
        immValid_ff <= (ea_pkg::mode_e'(mode_ff) == ea_pkg::MODE_IMMEDIATE);
        immValue_ff <= collect_ff[7:0];
        effAddr_ff <= eaSum;
      end
    end
  end
endmodule

/* File: dv/ea_gen_checker.sv */
// concurrent checks on the ports of the operand addressing unit
`timescale 1ns/1ns
module ea_gen_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [4:0] mode,
  input wire logic rmwOp,
  input wire logic [15:0] operandPc,
  input wire logic memRd_ff,
  input wire logic [15:0] memAddr_ff,
  input wire logic busy_ff,
  input wire logic done_ff,
  input wire logic modeError_ff,
  input wire logic [15:0] effAddr_ff,
  input wire logic [15:0] nextPc_ff,
  input wire logic [1:0] opBytes_ff
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic take; // request accepted by an idle unit
  logic refuse; // unknown code, or long mode on read-modify-write
  logic [4:0] takenMode_ff; // mode of the request in flight
  // mirrors the unit: any start seen while not busy is taken, done cycle too
  assign take = start && !busy_ff;
  assign refuse = (mode > 5'h10) || (rmwOp && (mode inside {ea_pkg::MODE_DIR_LONG,
    ea_pkg::MODE_IDX_LONG, ea_pkg::MODE_IND_LONG, ea_pkg::MODE_INDIDX_LONG}));
  // remember the mode so results can be judged at done
  always_ff @(posedge core_clk) begin
    if (reset) begin
      takenMode_ff <= 5'h00;
    end else if (take) begin
      takenMode_ff <= mode;
    end
  end
  // ----------------------------------------------------------------
  // sequences and assertions
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_take_mode(logic [4:0] m);
    take && !refuse && mode == m;
  endsequence
  sequence s_fetch_pc;
    memRd_ff && busy_ff && memAddr_ff == $past(operandPc);
  endsequence
  a_take_sets_busy: assert property (take && !refuse |=> busy_ff)
    else $error("accepted request did not raise busy");
  a_refuse_flagged: assert property (take && refuse |=> modeError_ff)
    else $error("refused request gave no error pulse");
  a_error_no_done: assert property (modeError_ff |-> !done_ff ##1 !done_ff)
    else $error("done followed an error pulse");
  a_noofs_two_cycles: assert property (s_take_mode(ea_pkg::MODE_IDX_NOOFS)
    |-> ##2 done_ff)
    else $error("no-offset indexed done not two cycles after take");
  a_inherent_no_fetch: assert property (s_take_mode(ea_pkg::MODE_INHERENT)
    |=> !memRd_ff && opBytes_ff == 2'h0 && nextPc_ff == $past(operandPc) ##1 done_ff)
    else $error("inherent request fetched or counted bytes");
  a_first_fetch_pc: assert property (take && !refuse
    && !(mode inside {ea_pkg::MODE_INHERENT, ea_pkg::MODE_IDX_NOOFS}) |=> s_fetch_pc)
    else $error("first operand fetch not at operand address");
  a_done_ends_busy: assert property (done_ff |-> !busy_ff && $past(busy_ff))
    else $error("done without preceding busy");
  a_short_page_zero: assert property (done_ff
    && (takenMode_ff inside {ea_pkg::MODE_DIR_SHORT, ea_pkg::MODE_IND_SHORT,
    ea_pkg::MODE_IDX_NOOFS}) |-> effAddr_ff[15:8] == 8'h00)
    else $error("short mode left page zero");
  a_idx_short_reach: assert property (done_ff
    && (takenMode_ff inside {ea_pkg::MODE_IDX_SHORT, ea_pkg::MODE_INDIDX_SHORT})
    |-> effAddr_ff <= 16'h01fe)
    else $error("short indexed address beyond reach");
  a_result_holds: assert property (!$past(reset) && $changed(effAddr_ff) |-> done_ff)
    else $error("effective address moved outside done");
endmodule
bind cpu_addressing_mode_ea_gen ea_gen_checker ea_gen_checker_inst (
  .core_clk(core_clk), .reset(reset), .start(start), .mode(mode), .rmwOp(rmwOp),
  .operandPc(operandPc), .memRd_ff(memRd_ff), .memAddr_ff(memAddr_ff), .busy_ff(busy_ff),
  .done_ff(done_ff), .modeError_ff(modeError_ff), .effAddr_ff(effAddr_ff),
  .nextPc_ff(nextPc_ff), .opBytes_ff(opBytes_ff)
);

/* File: dv/ea_mem_model.sv */
// program and data memory answering within the strobe cycle
`timescale 1ns/1ns
module ea_mem_model (
  input wire logic memRd_ff,
  input wire logic [15:0] memAddr_ff,
  output logic [7:0] memRdData
);
  logic [7:0] mem [0:65535]; // whole 64 Kbyte space, loaded by the bench
  // read straight off the registered address: the unit takes the byte at the
  // edge that ends its strobe cycle; with no strobe the bus shows the inverse,
  // so a byte taken at the wrong edge never matches
  assign memRdData = memRd_ff ? mem[memAddr_ff] : ~mem[memAddr_ff];
endmodule

/* File: dv/cpu_addressing_mode_ea_gen_tb.sv */
// self-checking bench of the operand addressing unit
`timescale 1ns/1ns
module cpu_addressing_mode_ea_gen_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic [4:0] mode = 5'h00;
  logic useSecondIndex = 1'b0;
  logic rmwOp = 1'b0;
  logic [15:0] operandPc = 16'h0000;
  logic [7:0] indexFirst = 8'h00;
  logic [7:0] indexSecond = 8'h00;
  logic [7:0] memRdData, immValue_ff;
  logic memRd_ff, busy_ff, done_ff, modeError_ff, immValid_ff;
  logic [15:0] memAddr_ff, effAddr_ff, nextPc_ff;
  logic [2:0] modeGroup_ff;
  logic [1:0] opBytes_ff;
  int bad_count = 0;
  int n_compared = 0;
  always #5 core_clk = ~core_clk;
  cpu_addressing_mode_ea_gen cpu_addressing_mode_ea_gen_inst (
    .core_clk(core_clk), .reset(reset), .start(start), .mode(mode),
    .useSecondIndex(useSecondIndex), .rmwOp(rmwOp), .operandPc(operandPc),
    .indexFirst(indexFirst), .indexSecond(indexSecond), .memRdData(memRdData),
    .memRd_ff(memRd_ff), .memAddr_ff(memAddr_ff), .busy_ff(busy_ff), .done_ff(done_ff),
    .modeError_ff(modeError_ff), .effAddr_ff(effAddr_ff), .immValue_ff(immValue_ff),
    .immValid_ff(immValid_ff), .nextPc_ff(nextPc_ff), .modeGroup_ff(modeGroup_ff),
    .opBytes_ff(opBytes_ff));
  ea_mem_model ea_mem_model_inst (.memRd_ff(memRd_ff), .memAddr_ff(memAddr_ff),
    .memRdData(memRdData));
  // ----------------------------------------------------------------
  // comparison, verdict and one request with its reference model
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hold keeps start high with a junk code while busy: it must be ignored
  task automatic go(input logic [4:0] m, input logic r, input logic [7:0] x,
    input logic [7:0] b0, input logic hold);
    logic [15:0] pc, e, pw;
    logic [7:0] b1;
    logic sel;
    int nb, lat, grp, cyc;
    pc = 16'($urandom_range(16'h0200, 16'hfdff)); // clear of pointer page
    b1 = 8'($urandom);
    sel = 1'($urandom);
    ea_mem_model_inst.mem[pc] = b0;
    ea_mem_model_inst.mem[pc + 16'h0001] = b1;
    pw = {ea_mem_model_inst.mem[{8'h00, b0}], ea_mem_model_inst.mem[{8'h00, b0} + 16'h0001]};
    nb = (m inside {5'h00, 5'h04}) ? 0 : (m inside {5'h03, 5'h06}) ? 2 : 1;
    lat = (nb == 0) ? 2 : (m inside {5'h07, 5'h09}) ? 4 : (m inside {5'h08, 5'h0a}) ? 5 : nb + 2;
    grp = (m < 5'h02) ? int'(m) : (m < 5'h04) ? 2 : (m < 5'h07) ? 3 : (m < 5'h0b) ? 4 :
      (m < 5'h0d) ? 5 : 6;
    case (m)
      5'h03: e = {b0, b1};
      5'h04: e = {8'h00, x};
      5'h05: e = {8'h00, b0} + {8'h00, x};
      5'h06: e = {b0, b1} + {8'h00, x};
      5'h07: e = {8'h00, pw[15:8]};
      5'h08: e = pw;
      5'h09: e = {8'h00, pw[15:8]} + {8'h00, x};
      5'h0a: e = pw + {8'h00, x};
      default: e = {8'h00, b0};
    endcase
    if (m > 5'h10 || (r && (m inside {5'h03, 5'h06, 5'h08, 5'h0a}))) lat = 1;
    @(posedge core_clk);
    #1;
    start = 1'b1;
    mode = m;
    rmwOp = r;
    useSecondIndex = sel;
    operandPc = pc;
    indexFirst = sel ? 8'($urandom) : x;
    indexSecond = sel ? x : 8'($urandom);
    @(posedge core_clk);
    #1;
    if (hold) mode = 5'h1f;
    else start = 1'b0;
    cyc = 1;
    while (!done_ff && !modeError_ff && cyc < 9) begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    start = 1'b0;
    if (lat == 1) begin
      chk("refused", {15'h0000, modeError_ff}, 16'h0001);
      chk("refuse cycle", 16'(cyc), 16'h0001);
    end else begin
      chk("group", {13'h0000, modeGroup_ff}, 16'(grp));
      if (m < 5'h0b) begin
        chk("latency", 16'(cyc), 16'(lat));
        chk("operand bytes", {14'h0000, opBytes_ff}, 16'(nb));
        chk("next pc", nextPc_ff, pc + 16'(nb));
        if (m != 5'h00) chk("effective address", effAddr_ff, e);
        chk("immediate flag", {15'h0000, immValid_ff}, {15'h0000, m == 5'h01});
        if (m == 5'h01) chk("immediate value", {8'h00, immValue_ff}, {8'h00, b0});
      end else begin
        chk("done seen", {15'h0000, done_ff}, 16'h0001);
      end
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'ha69d));
    for (int i = 0; i < 65536; i++) ea_mem_model_inst.mem[i] = 8'($urandom);
    repeat (5) @(posedge core_clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 17; i++) begin
      go(5'(i), 1'b0, 8'($urandom), 8'($urandom_range(0, 254)), 1'b0);
    end
    $display("test all modes done");
    for (int i = 0; i < 17; i++) begin
      go(5'(i), 1'b1, 8'($urandom), 8'($urandom_range(0, 254)), 1'b0);
    end
    go(5'h11, 1'b0, 8'h00, 8'h10, 1'b0);
    go(5'h1f, 1'b0, 8'h00, 8'h10, 1'b0);
    $display("test refusals done");
    go(5'h05, 1'b0, 8'hff, 8'hff, 1'b0);
    ea_mem_model_inst.mem[16'h00fe] = 8'hff;
    go(5'h09, 1'b0, 8'hff, 8'hfe, 1'b0);
    go(5'h06, 1'b0, 8'hff, 8'hff, 1'b0);
    go(5'h0a, 1'b0, 8'hff, 8'hfe, 1'b0);
    $display("test boundaries done");
    go(5'h07, 1'b0, 8'($urandom), 8'h20, 1'b1);
    go(5'h08, 1'b0, 8'($urandom), 8'h30, 1'b1);
    $display("test start while busy done");
    // reset in mid-request, then the unit must serve again
    @(posedge core_clk);
    #1;
    start = 1'b1;
    mode = 5'h08;
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b1;
    start = 1'b0;
    @(posedge core_clk);
    #1 reset = 1'b0;
    chk("busy after reset", {15'h0000, busy_ff}, 16'h0000);
    go(5'h08, 1'b0, 8'($urandom), 8'h40, 1'b0);
    $display("test mid-run reset done");
    give_verdict();
  end
  // forty-three requests of under ten cycles each; wide margin
  initial begin
    #50000;
    bad_count++;
    give_verdict();
  end
endmodule
